// File: rbc_dr_track.sv
/*
 * Delayed read entry tracker for one interface: latches a retried read and
 * judges each repeat. Decisions are combinational; the caller registers them.
 */
`timescale 1ns/1ps
`default_nettype none

module rbc_dr_track (
    input wire logic i_clk_sys, // System clock
    input wire logic i_reset_n, // Asynchronous reset, active low
    input wire rbc_pkg::rbc_rd_req_t i_req, // Read attempt from a bus master
    input wire logic i_pcix, // Interface runs PCI-X
    input wire logic i_sdr_en, // Command changes allowed after retry
    output logic o_retry, // Attempt is retried this cycle
    output logic o_complete, // Attempt completes this cycle
    output logic o_held // A delayed read entry is pending
);

    logic held;
    logic next_held;
    rbc_pkg::rbc_rd_req_t entry;
    rbc_pkg::rbc_rd_req_t next_entry;
    logic same_target;
    logic mem_pair;

    assign o_held = held;

    always_comb begin
        next_held = held;
        next_entry = entry;
        o_retry = 1'b0;
        o_complete = 1'b0;
        same_target = (i_req.addr == entry.addr) && (i_req.be == entry.be);
        mem_pair = (i_req.cmd != rbc_pkg::CMD_OTHER) && (entry.cmd != rbc_pkg::CMD_OTHER);
        if (i_req.valid) begin
            if (!held) begin
                next_held = 1'b1;
                next_entry = i_req;
                o_retry = 1'b1;
            end else if (same_target && (i_req.cmd == entry.cmd)) begin
                next_held = 1'b0;
                o_complete = 1'b1;
            end else if (same_target && mem_pair && i_sdr_en && !i_pcix) begin // R9 R10
                next_held = 1'b0;
                o_complete = 1'b1;
            end else begin
                o_retry = 1'b1; // R8
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            held <= 1'b0;
            entry <= '0;
        end else begin
            held <= next_held;
            entry <= next_entry;
        end
    end

endmodule

`default_nettype wire

// File: rbc_pci_master.sv
/* Behavioural PCI master for one bridge interface: read attempts and
   completions as one-cycle pulses. Assumes the bench calls its tasks. */
`timescale 1ns/1ps
`default_nettype none

module rbc_pci_master (
    input wire logic i_clk_sys, // Clock
    output var rbc_pkg::rbc_rd_req_t o_req, // Read attempt
    output var rbc_pkg::rbc_cpl_t o_cpl // Completion offered
);
    // ==========================================================
    // Drive
    initial begin
        o_req = '0;
        o_cpl = '0;
    end

    // Gap idles the master first
    task automatic attempt(input rbc_pkg::rbc_cmd_t c, input logic pf, input logic [31:0] a,
                           input logic [3:0] be, input int gap);
        repeat (gap) @(posedge i_clk_sys);
        @(posedge i_clk_sys);
        o_req <= '{1'b1, c, pf, a, be};
        @(posedge i_clk_sys);
        // Released lines must not keep looking valid
        o_req <= '{1'b0, rbc_pkg::CMD_OTHER, ~pf, ~a, ~be};
    endtask

    task automatic complete(input logic ro);
        @(posedge i_clk_sys);
        o_cpl <= '{1'b1, ro};
        @(posedge i_clk_sys);
        o_cpl <= '{1'b0, ~ro};
    endtask
endmodule
`default_nettype wire

// File: rbc_pf_decode.sv
/*
 * Prefetch mode and byte count decode for one interface.
 * Combinational; the caller registers it.
 */
`timescale 1ns/1ps
`default_nettype none

module rbc_pf_decode (
    input wire rbc_pkg::rbc_side_cfg_t i_cfg, // Interface half of the control word
    input wire rbc_pkg::rbc_cmd_t i_cmd, // Memory read command of the request
    input wire logic i_prefetchable, // Address falls in a prefetchable range
    input wire logic i_pcix, // Interface runs PCI-X
    output rbc_pkg::rbc_pf_t o_mode, // Selected prefetch behaviour
    output logic [12:0] o_byte_count // Decoded maximum read byte count
);

    always_comb begin
        case (i_cfg.max_cnt)
            rbc_pkg::MC_128: o_byte_count = rbc_pkg::BC_128; // R1
            rbc_pkg::MC_256: o_byte_count = rbc_pkg::BC_256; // R1
            rbc_pkg::MC_1024: o_byte_count = rbc_pkg::BC_1024; // R1
            rbc_pkg::MC_2048: o_byte_count = rbc_pkg::BC_2048; // R1
            rbc_pkg::MC_4096: o_byte_count = rbc_pkg::BC_4096; // R1
            default: o_byte_count = rbc_pkg::BC_512; // R1
        endcase
    end

    always_comb begin
        o_mode = rbc_pkg::PF_NONE;
        // Fields carry no meaning in PCI-X mode or outside a prefetchable range
        if (!i_pcix && i_prefetchable) begin // R12
            case (i_cmd)
                rbc_pkg::CMD_MR: begin
                    if (i_cfg.pf_mr == rbc_pkg::PF_CODE_LINE) o_mode = rbc_pkg::PF_LINE; // R11
                    else if (i_cfg.pf_mr == rbc_pkg::PF_CODE_FULL) o_mode = rbc_pkg::PF_FULL; // R11
                    else if (i_cfg.pf_mr == rbc_pkg::PF_CODE_DISC) o_mode = rbc_pkg::PF_DISC_DW; // R11
                end
                rbc_pkg::CMD_MRL: begin
                    if (i_cfg.pf_mrl == rbc_pkg::PF_CODE_LINE) o_mode = rbc_pkg::PF_LINE; // R13
                    else if (i_cfg.pf_mrl == rbc_pkg::PF_CODE_FULL) o_mode = rbc_pkg::PF_FULL; // R13
                end
                rbc_pkg::CMD_MRM: begin
                    if (i_cfg.pf_mrm == rbc_pkg::PF_CODE_LINE) o_mode = rbc_pkg::PF_LINE; // R14
                    else if (i_cfg.pf_mrm == rbc_pkg::PF_CODE_FULL) o_mode = rbc_pkg::PF_FULL; // R14
                end
                default: o_mode = rbc_pkg::PF_NONE;
            endcase
        end
    end

endmodule

`default_nettype wire

// File: rbc_pkg.sv
/*
 * Constants, field layout and carrier types for read buffering control.
 * Assumes one clock domain.
 */
package rbc_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] REG_BUF_CTRL = 8'h40;
    localparam logic [7:0] REG_STATUS = 8'h4c;

    // ==========================================================
    // Field positions and masks
    localparam int unsigned HALF_W = 16;
    localparam int unsigned SEC_LSB = 16;
    localparam int unsigned MAXCNT_LSB = 12;
    localparam int unsigned RO_EN_BIT = 11;
    localparam int unsigned SDR_EN_BIT = 10;
    localparam int unsigned PF_MR_LSB = 8;
    localparam int unsigned PF_MRL_LSB = 6;
    localparam int unsigned PF_MRM_LSB = 4;
    localparam logic [31:0] CTRL_RW_MASK = 32'h7ff0_7ff0;
    localparam logic [31:0] CTRL_RESET = 32'h0020_0000;

    // ==========================================================
    // Encodings
    localparam logic [1:0] PF_CODE_LINE = 2'h0;
    localparam logic [1:0] PF_CODE_FULL = 2'h2;
    localparam logic [1:0] PF_CODE_DISC = 2'h3;
    localparam logic [2:0] MC_128 = 3'h1;
    localparam logic [2:0] MC_256 = 3'h2;
    localparam logic [2:0] MC_1024 = 3'h4;
    localparam logic [2:0] MC_2048 = 3'h5;
    localparam logic [2:0] MC_4096 = 3'h6;
    localparam logic [12:0] BC_128 = 13'h0080;
    localparam logic [12:0] BC_256 = 13'h0100;
    localparam logic [12:0] BC_512 = 13'h0200;
    localparam logic [12:0] BC_1024 = 13'h0400;
    localparam logic [12:0] BC_2048 = 13'h0800;
    localparam logic [12:0] BC_4096 = 13'h1000;

    typedef enum logic [1:0] {CMD_MR, CMD_MRL, CMD_MRM, CMD_OTHER} rbc_cmd_t;
    typedef enum logic [1:0] {PF_NONE, PF_LINE, PF_FULL, PF_DISC_DW} rbc_pf_t;

    // Half-word layout shared by both interfaces, MSB first
    typedef struct packed {
        logic rsvd_hi;
        logic [2:0] max_cnt;
        logic ro_en;
        logic sdr_en;
        logic [1:0] pf_mr;
        logic [1:0] pf_mrl;
        logic [1:0] pf_mrm;
        logic [3:0] rsvd_lo;
    } rbc_side_cfg_t;

    typedef struct packed {
        logic valid;
        rbc_cmd_t cmd;
        logic prefetchable;
        logic [31:0] addr;
        logic [3:0] be;
    } rbc_rd_req_t;

    typedef struct packed {
        logic valid;
        logic attr_ro;
    } rbc_cpl_t;

    typedef struct packed {
        rbc_pf_t pf_mode;
        logic [12:0] byte_count;
        logic dr_retry;
        logic dr_complete;
        logic cpl_bypass;
    } rbc_side_out_t;

endpackage

// File: rbc_read_buf_ctrl.sv
/*
 * Bridge read buffering control: register slave, prefetch decode, delayed
 * reads and completion order. Index 0 is primary, 1 secondary.
 * Assumes synchronous inputs and a master that waits for waitrequest low.
 */
// What this block does
// R1: The three-bit maximum read byte count decodes to 128, 256, 1024, 2048 or 4096 bytes, other codes to 512.
// R2: Full-prefetch reads from a conventional primary are sized on the secondary by the primary byte count.
// R3: Both byte count fields reset to code 000, meaning 512 bytes.
// R4: Full-prefetch reads from a conventional secondary are sized on the primary by the secondary count in bits 30:28.
// R5: The primary relaxed ordering enable lets later read completions pass posted writes; cleared it disables this.
// R6: The secondary relaxed ordering enable does the same at the secondary interface.
// R7: In PCI-X mode the attribute relaxed ordering bit decides instead of the enable bits.
// R8: With special delayed read cleared, a repeat with a changed command is retried.
// R9: With special delayed read set, MR, MRL and MRM may be swapped and the read completes if address and enables match.
// R10: Special delayed read is ignored in PCI-X mode and resets to 0.
// R11: Memory read prefetch field: 00 one line, 10 full, 11 disconnect after first dword, 01 reserved.
// R12: The memory read prefetch field is ignored in PCI-X mode and resets to 00.
// R13: Memory read line field: 00 one line, 10 full, others reserved, ignored in PCI-X mode.
// R14: Memory read multiple field: 00 one line, 10 full, others reserved, ignored in PCI-X mode.
`timescale 1ns/1ps
`default_nettype none

module rbc_read_buf_ctrl #(
    parameter int unsigned NUM_SIDES = 2 // Primary and secondary interface
) (
    input wire logic i_clk_sys, // System clock, 100 MHz
    input wire logic i_reset_n, // Asynchronous reset, active low
    input wire logic [rbc_pkg::ADDR_W-1:0] i_avs_address, // Byte address
    input wire logic i_avs_read, // Read request
    input wire logic i_avs_write, // Write request
    input wire logic [31:0] i_avs_writedata, // Write data
    input wire logic [3:0] i_avs_byteenable, // Byte lanes of a write
    output logic [31:0] o_avs_readdata, // Read data, valid with waitrequest low
    output logic o_avs_waitrequest, // Low for the one answering cycle
    input wire logic [NUM_SIDES-1:0] i_pcix_mode, // Interface runs PCI-X
    input wire rbc_pkg::rbc_rd_req_t [NUM_SIDES-1:0] i_rd_req, // Read attempts
    input wire logic [NUM_SIDES-1:0] i_posted_pending, // Posted writes are queued
    input wire rbc_pkg::rbc_cpl_t [NUM_SIDES-1:0] i_cpl, // Read completion offered
    output rbc_pkg::rbc_side_out_t [NUM_SIDES-1:0] o_side // Registered decisions
);

    // ==========================================================
    // Bus slave state
    typedef enum logic {BUS_IDLE, BUS_ACK} rbc_bus_state_t;

    rbc_bus_state_t bus_state;
    rbc_bus_state_t next_bus_state;
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic wait_req;
    logic next_wait_req;
    logic hit_ctrl;
    logic hit_status;
    logic [31:0] status_word;

    // ==========================================================
    // Per-interface wiring
    rbc_pkg::rbc_side_out_t side_next [NUM_SIDES];
    logic [NUM_SIDES-1:0] held;
    logic [NUM_SIDES-1:0] seen_first;

    assign o_avs_readdata = rdata;
    assign o_avs_waitrequest = wait_req;

    // Word-aligned decode; the two low address bits select no lane here
    assign hit_ctrl = (i_avs_address[rbc_pkg::ADDR_W-1:2] == rbc_pkg::REG_BUF_CTRL[rbc_pkg::ADDR_W-1:2]);
    assign hit_status = (i_avs_address[rbc_pkg::ADDR_W-1:2] == rbc_pkg::REG_STATUS[rbc_pkg::ADDR_W-1:2]);

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[1:0] = held;
        status_word[9:8] = seen_first;
        status_word[17:16] = i_pcix_mode;
    end

    // ==========================================================
    // Avalon-MM slave
    // Answer one cycle after the request; a write lands as the master sees waitrequest low
    always_comb begin
        next_bus_state = bus_state;
        next_ctrl = ctrl;
        next_rdata = rdata;
        next_wait_req = 1'b1;
        case (bus_state)
            BUS_IDLE: begin
                if (i_avs_read || i_avs_write) begin
                    next_bus_state = BUS_ACK;
                    next_wait_req = 1'b0;
                    if (i_avs_read) begin
                        if (hit_ctrl) begin
                            next_rdata = ctrl & rbc_pkg::CTRL_RW_MASK;
                        end else if (hit_status) begin
                            next_rdata = status_word;
                        end else begin
                            next_rdata = 32'h0000_0000;
                        end
                    end
                end
            end
            BUS_ACK: begin
                next_bus_state = BUS_IDLE;
                if (i_avs_write && hit_ctrl) begin
                    for (int b = 0; b < 4; b++) begin
                        if (i_avs_byteenable[b]) begin
                            next_ctrl[8*b +: 8] = i_avs_writedata[8*b +: 8] & rbc_pkg::CTRL_RW_MASK[8*b +: 8];
                        end
                    end
                end
            end
            default: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bus_state <= BUS_IDLE;
            ctrl <= rbc_pkg::CTRL_RESET; // R3 R10 R12
            rdata <= 32'h0000_0000;
            wait_req <= 1'b1;
        end else begin
            bus_state <= next_bus_state;
            ctrl <= next_ctrl;
            rdata <= next_rdata;
            wait_req <= next_wait_req;
        end
    end

    // ==========================================================
    // Per-interface policy
    for (genvar s = 0; s < NUM_SIDES; s++) begin : g_side
        rbc_pkg::rbc_side_cfg_t cfg;
        rbc_pkg::rbc_pf_t pf_mode;
        logic [12:0] byte_count;
        logic dr_retry;
        logic dr_complete;
        logic ro_allow;
        logic next_seen_first;

        // Secondary half sits 16 bits up, so bits 30:28 hold its byte count
        assign cfg = rbc_pkg::rbc_side_cfg_t'(ctrl[s*rbc_pkg::HALF_W +: rbc_pkg::HALF_W]); // R4

        rbc_pf_decode u_pf_decode (
            .i_cfg(cfg),
            .i_cmd(i_rd_req[s].cmd),
            .i_prefetchable(i_rd_req[s].prefetchable),
            .i_pcix(i_pcix_mode[s]),
            .o_mode(pf_mode),
            .o_byte_count(byte_count)
        );

        rbc_dr_track u_dr_track (
            .i_clk_sys(i_clk_sys),
            .i_reset_n(i_reset_n),
            .i_req(i_rd_req[s]),
            .i_pcix(i_pcix_mode[s]),
            .i_sdr_en(cfg.sdr_en),
            .o_retry(dr_retry),
            .o_complete(dr_complete),
            .o_held(held[s])
        );

        // The first completion of a read keeps strict order; only later ones
        // may pass. A completing delayed read rearms this.
        always_comb begin
            next_seen_first = seen_first[s];
            if (dr_complete) begin
                next_seen_first = 1'b0;
            end else if (i_cpl[s].valid) begin
                next_seen_first = 1'b1;
            end
        end

        always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
            if (!i_reset_n) begin
                seen_first[s] <= 1'b0;
            end else begin
                seen_first[s] <= next_seen_first;
            end
        end

        always_comb begin
            if (i_pcix_mode[s]) begin
                ro_allow = i_cpl[s].attr_ro; // R7
            end else begin
                ro_allow = cfg.ro_en; // R5 R6
            end
        end

        always_comb begin
            side_next[s].pf_mode = pf_mode;
            // Only a conventional full prefetch is sized by the byte count
            if (i_rd_req[s].valid && (pf_mode == rbc_pkg::PF_FULL)) begin
                side_next[s].byte_count = byte_count; // R2 R4
            end else begin
                side_next[s].byte_count = 13'h0000;
            end
            side_next[s].dr_retry = dr_retry;
            side_next[s].dr_complete = dr_complete;
            side_next[s].cpl_bypass = i_cpl[s].valid && i_posted_pending[s] && seen_first[s] && ro_allow; // R5 R6 R7
        end
    end

    // ==========================================================
    // Output registers
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_side <= '0;
        end else begin
            for (int s = 0; s < NUM_SIDES; s++) begin
                o_side[s] <= side_next[s];
            end
        end
    end

endmodule

`default_nettype wire

// File: rbc_read_buf_ctrl_chk.sv
/* Port checks for read buffering control.
   Assumes it is bound to the top module. */
`timescale 1ns/1ps
`default_nettype none

module rbc_read_buf_ctrl_chk #(
    parameter int unsigned NUM_SIDES = 2 // Interfaces
) (
    input wire logic i_clk_sys, // Clock
    input wire logic i_reset_n, // Reset, active low
    input wire logic i_avs_read, // Read request
    input wire logic i_avs_write, // Write request
    input wire logic o_avs_waitrequest, // Wait
    input wire logic [NUM_SIDES-1:0] i_pcix_mode, // PCI-X mode
    input wire logic [NUM_SIDES-1:0] i_posted_pending, // Posted writes
    input wire rbc_pkg::rbc_rd_req_t [NUM_SIDES-1:0] i_rd_req, // Attempts
    input wire rbc_pkg::rbc_cpl_t [NUM_SIDES-1:0] i_cpl, // Completions
    input wire rbc_pkg::rbc_side_out_t [NUM_SIDES-1:0] o_side // Decisions
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    wait_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("wait low twice");
    req_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("no answer");
    pcix_none_a: assert property (i_pcix_mode[0]
        |=> o_side[0].pf_mode == rbc_pkg::PF_NONE && o_side[0].byte_count == 13'h0000)
        else $error("prefetch in PCI-X");
    bc_legal_a: assert property (o_side[0].byte_count != 13'h0000
        |-> o_side[0].byte_count inside {13'h0080, 13'h0100, 13'h0200, 13'h0400, 13'h0800, 13'h1000})
        else $error("bad byte count");
    pri_bc_full_a: assert property (o_side[0].byte_count != 13'h0000
        |-> o_side[0].pf_mode == rbc_pkg::PF_FULL && !$past(i_pcix_mode[0]))
        else $error("primary count");
    sec_bc_full_a: assert property (o_side[1].byte_count != 13'h0000
        |-> o_side[1].pf_mode == rbc_pkg::PF_FULL && !$past(i_pcix_mode[1]))
        else $error("secondary count");
    dr_answer_a: assert property (i_rd_req[0].valid |=> o_side[0].dr_retry ^ o_side[0].dr_complete)
        else $error("no decision");
    dr_quiet_a: assert property (!i_rd_req[0].valid |=> !o_side[0].dr_retry && !o_side[0].dr_complete)
        else $error("stray decision");
    pri_bypass_a: assert property (o_side[0].cpl_bypass
        |-> $past(i_cpl[0].valid) && $past(i_posted_pending[0]))
        else $error("primary bypass");
    sec_bypass_a: assert property (o_side[1].cpl_bypass
        |-> $past(i_cpl[1].valid) && $past(i_posted_pending[1]))
        else $error("secondary bypass");
    attr_ro_a: assert property (i_pcix_mode[0] && i_cpl[0].valid && !i_cpl[0].attr_ro
        |=> !o_side[0].cpl_bypass)
        else $error("PCI-X bypass");

    cover property (o_side[0].dr_complete);
    cover property (o_side[1].cpl_bypass);
    cover property (o_side[0].byte_count == 13'h1000);
endmodule

bind rbc_read_buf_ctrl rbc_read_buf_ctrl_chk #(.NUM_SIDES(NUM_SIDES)) rbc_read_buf_ctrl_chk_inst (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_pcix_mode(i_pcix_mode),
    .i_posted_pending(i_posted_pending),
    .i_rd_req(i_rd_req),
    .i_cpl(i_cpl),
    .o_side(o_side)
);
`default_nettype wire

// File: rbc_read_buf_ctrl_tb.sv
/* Self-checking bench: Avalon-MM register traffic, two PCI masters and a
   bench model that predicts every decision. Assumes the bound checker. */
`timescale 1ns/1ps
`default_nettype none

module rbc_read_buf_ctrl_tb;
    logic i_clk_sys;
    logic i_reset_n = 1'b0;
    logic [7:0] i_avs_address = 8'h00;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0000_0000;
    logic [3:0] i_avs_byteenable = 4'h0;
    logic [1:0] i_pcix_mode = 2'h0;
    logic [1:0] i_posted_pending = 2'h0;
    wire logic [31:0] o_avs_readdata;
    wire logic o_avs_waitrequest;
    wire rbc_pkg::rbc_rd_req_t [1:0] i_rd_req;
    wire rbc_pkg::rbc_cpl_t [1:0] i_cpl;
    wire rbc_pkg::rbc_side_out_t [1:0] o_side;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    integer seed;
    logic [31:0] ctrl_m, q, d;
    logic [3:0] b;
    int held[2], seen[2];
    logic [31:0] h_addr[2];
    logic [3:0] h_be[2];
    rbc_pkg::rbc_cmd_t h_cmd[2];

    rbc_read_buf_ctrl #(.NUM_SIDES(2)) rbc_read_buf_ctrl_inst (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest),
        .i_pcix_mode(i_pcix_mode),
        .i_rd_req(i_rd_req),
        .i_posted_pending(i_posted_pending),
        .i_cpl(i_cpl),
        .o_side(o_side)
    );
    rbc_pci_master pm0 (.i_clk_sys(i_clk_sys), .o_req(i_rd_req[0]), .o_cpl(i_cpl[0]));
    rbc_pci_master pm1 (.i_clk_sys(i_clk_sys), .o_req(i_rd_req[1]), .o_cpl(i_cpl[1]));

    // ==========================================================
    // Model and helpers
    function automatic rbc_pkg::rbc_pf_t pf_of(input rbc_pkg::rbc_cmd_t c, input logic [1:0] k, input logic off);
        if (off || c == rbc_pkg::CMD_OTHER) return rbc_pkg::PF_NONE;
        if (k == 2'h0) return rbc_pkg::PF_LINE;
        if (k == 2'h2) return rbc_pkg::PF_FULL;
        // Disconnect exists only for plain memory read
        if (k == 2'h3 && c == rbc_pkg::CMD_MR) return rbc_pkg::PF_DISC_DW;
        return rbc_pkg::PF_NONE;
    endfunction

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic chk_side(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic avs(input logic we, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be,
                       output logic [31:0] rd);
        @(posedge i_clk_sys);
        i_avs_read <= !we;
        i_avs_write <= we;
        i_avs_address <= a;
        i_avs_writedata <= wd;
        i_avs_byteenable <= be;
        do @(posedge i_clk_sys); while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask

    task automatic do_reset();
        i_reset_n <= 1'b0;
        repeat (5) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        ctrl_m = 32'h0020_0000;
        held = '{0, 0};
        seen = '{0, 0};
    endtask

    task automatic side_step(input int s);
        logic [31:0] r, a;
        logic [15:0] h;
        logic [3:0] be;
        logic [1:0] k;
        rbc_pkg::rbc_cmd_t c;
        rbc_pkg::rbc_pf_t ep;
        logic er, ec, eb;
        r = $random(seed);
        h = 16'(ctrl_m >> (16 * s));
        c = rbc_pkg::rbc_cmd_t'(r[3:2]);
        a = (held[s] != 0 && r[1:0] != 2'h0) ? h_addr[s] : $random(seed);
        be = (held[s] != 0 && a == h_addr[s]) ? h_be[s] : 4'($random(seed));
        er = 1'b1;
        ec = 1'b0;
        if (held[s] == 0) begin
            held[s] = 1;
            h_addr[s] = a;
            h_be[s] = be;
            h_cmd[s] = c;
        end else if (a == h_addr[s] && be == h_be[s] && (c == h_cmd[s] || (h[10] && !i_pcix_mode[s]
                     && c != rbc_pkg::CMD_OTHER && h_cmd[s] != rbc_pkg::CMD_OTHER))) begin
            er = 1'b0;
            ec = 1'b1;
            held[s] = 0;
            seen[s] = 0;
        end
        k = 2'(h >> (8 - 2 * int'(c)));
        ep = pf_of(c, k, i_pcix_mode[s] || !r[4]);
        if (s == 0) pm0.attempt(c, r[4], a, be, int'(r[6:5]));
        else pm1.attempt(c, r[4], a, be, int'(r[6:5]));
        #1;
        chk_side("dr_retry", 16'(er), 16'(o_side[s].dr_retry));
        chk_side("dr_complete", 16'(ec), 16'(o_side[s].dr_complete));
        chk_side("pf_mode", 16'(ep), 16'(o_side[s].pf_mode));
        chk_side("byte_count", (ep != rbc_pkg::PF_FULL) ? 16'h0000 : (h[14:12] inside {3'h0, 3'h3, 3'h7}) ? 16'h0200
                 : 16'h0040 << h[14:12], 16'(o_side[s].byte_count));
        @(posedge i_clk_sys);
        i_posted_pending[s] <= r[7];
        eb = seen[s] != 0 && r[7] && (i_pcix_mode[s] ? r[8] : h[11]);
        seen[s] = 1;
        if (s == 0) pm0.complete(r[8]);
        else pm1.complete(r[8]);
        #1;
        chk_side("cpl_bypass", 16'(eb), 16'(o_side[s].cpl_bypass));
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock, timeout and sequence
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        seed = 32'hbad18c36;
        do_reset();
        avs(1'b0, rbc_pkg::REG_BUF_CTRL, 32'h0000_0000, 4'h0, q);
        chk_reg("ctrl reset", 32'h0020_0000, q);
        avs(1'b1, rbc_pkg::REG_BUF_CTRL, 32'hffff_ffff, 4'hf, q);
        avs(1'b1, 8'h80, 32'h0000_0000, 4'hf, q);
        avs(1'b0, 8'h80, 32'h0000_0000, 4'h0, q);
        chk_reg("unmapped", 32'h0000_0000, q);
        avs(1'b0, rbc_pkg::REG_BUF_CTRL, 32'h0000_0000, 4'h0, q);
        chk_reg("ctrl ones", rbc_pkg::CTRL_RW_MASK, q);
        ctrl_m = q;
        repeat (4) begin
            d = $random(seed);
            b = 4'($random(seed));
            avs(1'b1, rbc_pkg::REG_BUF_CTRL, d, b, q);
            for (int i = 0; i < 4; i++) begin
                if (b[i]) ctrl_m[8*i +: 8] = d[8*i +: 8];
            end
            ctrl_m = ctrl_m & rbc_pkg::CTRL_RW_MASK;
            avs(1'b0, rbc_pkg::REG_BUF_CTRL, 32'h0000_0000, 4'h0, q);
            chk_reg("ctrl lanes", ctrl_m, q);
        end
        // Every byte count code on both sides, PCI-X now and then
        for (int it = 0; it < 64; it++) begin
            d = $random(seed) & rbc_pkg::CTRL_RW_MASK;
            d[14:12] = 3'(it);
            d[30:28] = 3'(it + 3);
            // Settles during the write, before the model reads it
            i_pcix_mode <= (it % 4 == 3) ? 2'($random(seed)) : 2'h0;
            avs(1'b1, rbc_pkg::REG_BUF_CTRL, d, 4'hf, q);
            ctrl_m = d;
            side_step(0);
            side_step(1);
        end
        avs(1'b0, rbc_pkg::REG_STATUS, 32'h0000_0000, 4'h0, q);
        chk_reg("status", {14'h0000, i_pcix_mode, 6'h00, seen[1] != 0, seen[0] != 0, 6'h00,
                           held[1] != 0, held[0] != 0}, q);
        do_reset();
        avs(1'b0, rbc_pkg::REG_BUF_CTRL, 32'h0000_0000, 4'h0, q);
        chk_reg("ctrl second reset", 32'h0020_0000, q);
        summarize();
    end
endmodule
`default_nettype wire
